// ==== dv/sys_clk_ctrl_test.sv ====
// self-checking bench for the system clock source control
// assumes the bench drives every port itself; source clocks come from hclk counters
`timescale 1ns/1ps
module sys_clk_ctrl_test;
  // ==========================================================
  // signals and counters
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic ext_clock_pin, crystal_input_pin, int_clk_src, wakeup_clk_src;
  logic sys_clk, sys_clk_rise, pll_enable, flash_req, flash_seq, flash_ready;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] rd;
  int per, hi, rises, i;
  logic rdy0;
  int k1_fld[3] = '{0, 2, 1023};
  int k1_per[3] = '{4, 12, 4096};
  int k1_hi[3] = '{2, 8, 2048};

  sys_clk_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_clock_pin(ext_clock_pin),
    .crystal_input_pin(crystal_input_pin), .int_clk_src(int_clk_src),
    .wakeup_clk_src(wakeup_clk_src), .sys_clk(sys_clk), .sys_clk_rise(sys_clk_rise),
    .pll_enable(pll_enable), .flash_req(flash_req), .flash_seq(flash_seq),
    .flash_ready(flash_ready));

  assign hready = hreadyout; // single slave drives bus ready

  // ==========================================================
  // clock, source pins (periods 6, 4, 8, 16 hclk)
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    ext_clock_pin <= ((cyc / 3) % 2) == 1;
    crystal_input_pin <= ((cyc / 2) % 2) == 1;
    int_clk_src <= ((cyc / 4) % 2) == 1;
    wakeup_clk_src <= ((cyc / 8) % 2) == 1;
  end

  // ==========================================================
  // compare, report and bus tasks
  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("errors %0d comparisons %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one single-word transfer: address phase, then data phase
  task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb_xfer(1'b1, a, d, q);
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    ahb_xfer(1'b0, a, 32'h00000000, q);
    check_data(q & m, exp);
  endtask

  // poll status until the given bit reaches the given level
  task automatic poll(input int b, input logic lvl);
    logic [31:0] q;
    for (int n = 0; n < 2000; n++) begin
      ahb_xfer(1'b0, clk_ctrl_pkg::OFS_STATUS, 32'h00000000, q);
      if (q[b] === lvl) break;
    end
  endtask

  // cycles and high cycles over n system clock periods
  task automatic measure(input int n, output int cycles, output int high);
    int k;
    cycles = 0;
    high = 0;
    k = 0;
    for (int w = 0; w < 10000 && sys_clk_rise !== 1'b1; w++) @(negedge hclk);
    while (k < n && cycles < 20000) begin
      @(negedge hclk);
      cycles++;
      if (sys_clk === 1'b1) high++;
      if (sys_clk_rise === 1'b1) k++;
    end
  endtask

  // one flash access; counts system clock rises until ready
  task automatic flash_acc(input logic seq, output int cnt, output logic first);
    @(posedge hclk);
    flash_req <= 1'b1;
    flash_seq <= seq;
    @(negedge hclk);
    first = flash_ready;
    cnt = 0;
    for (int w = 0; w < 2000 && !seq; w++) begin
      @(negedge hclk);
      if (flash_ready === 1'b1) break;
      if (sys_clk_rise === 1'b1) cnt++;
    end
    @(posedge hclk);
    flash_req <= 1'b0;
    flash_seq <= 1'b0;
  endtask

  // ==========================================================
  // watchdog
  initial begin
    #(80000 * 50);
    n_errors++;
    complete_run;
  end

  // ==========================================================
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    flash_req = 1'b0;
    flash_seq = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, unmapped read
    rd_check(clk_ctrl_pkg::OFS_SYS_CFG, 32'h00000040, 32'hffffffff);
    rd_check(clk_ctrl_pkg::OFS_PLL_CFG, 32'h00000001, 32'hffffffff);
    rd_check(clk_ctrl_pkg::OFS_PRESCALE, 32'h00000000, 32'hffffffff);
    rd_check(8'h14, 32'h00000000, 32'hffffffff);
    // zero waitstates refused, direct drive taken
    wr(clk_ctrl_pkg::OFS_SYS_CFG, 32'h00000003);
    rd_check(clk_ctrl_pkg::OFS_SYS_CFG, 32'h00000043, 32'hffffffff);
    poll(1, 1'b0);
    rd_check(clk_ctrl_pkg::OFS_STATUS, 32'h00000030, 32'h0000003a);
    measure(1, per, hi);
    check_count(per, 6);
    check_count(hi, 3);
    // waitstate counts 1..4, sequential and not
    for (i = 1; i <= 4; i++) begin
      wr(clk_ctrl_pkg::OFS_SYS_CFG, (i << 4) | 3);
      flash_acc(1'b1, rises, rdy0);
      check_data({31'h0, rdy0}, 32'h00000001);
      flash_acc(1'b0, rises, rdy0);
      check_data({31'h0, rdy0}, 32'h00000000);
      check_count(rises, i);
    end
    // prescaler from crystal, factors 1, 3, 1024
    wr(clk_ctrl_pkg::OFS_PLL_CFG, 32'h00000001);
    wr(clk_ctrl_pkg::OFS_SYS_CFG, 32'h00000042);
    for (i = 0; i < 3; i++) begin
      wr(clk_ctrl_pkg::OFS_PRESCALE, k1_fld[i]);
      poll(1, 1'b0);
      measure(1, per, hi);
      check_count(per, k1_per[i]);
      check_count(hi, k1_hi[i]);
    end
    // prescaler from internal source
    wr(clk_ctrl_pkg::OFS_PRESCALE, 32'h00000000);
    wr(clk_ctrl_pkg::OFS_PLL_CFG, 32'h00000003);
    poll(1, 1'b0);
    measure(1, per, hi);
    check_count(per, 8);
    // reserved select and band codes keep old values
    wr(clk_ctrl_pkg::OFS_SYS_CFG, 32'h00000041);
    rd_check(clk_ctrl_pkg::OFS_SYS_CFG, 32'h00000042, 32'hffffffff);
    wr(clk_ctrl_pkg::OFS_PLL_CFG, 32'h00000007);
    rd_check(clk_ctrl_pkg::OFS_PLL_CFG, 32'h00000007, 32'hffffffff);
    wr(clk_ctrl_pkg::OFS_PLL_CFG, 32'h0000000b);
    rd_check(clk_ctrl_pkg::OFS_PLL_CFG, 32'h00000007, 32'hffffffff);
    // pll from internal source, N=2, K2=1 then K2=2
    for (i = 0; i < 2; i++) begin
      wr(clk_ctrl_pkg::OFS_PLL_CFG, 32'h00000102 | (i << 16));
      poll(2, 1'b1);
      poll(1, 1'b0);
      check_data({31'h0, pll_enable}, 32'h00000001);
      rd_check(clk_ctrl_pkg::OFS_STATUS, 32'h0000002c, 32'h0000003e);
      measure(4, per, hi);
      check_count(per, 16 * (i + 1));
    end
    // wakeup source
    wr(clk_ctrl_pkg::OFS_SYS_CFG, 32'h00000040);
    poll(1, 1'b0);
    check_data({31'h0, pll_enable}, 32'h00000000);
    measure(1, per, hi);
    check_count(per, 16);
    // second reset in mid-run
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_check(clk_ctrl_pkg::OFS_SYS_CFG, 32'h00000040, 32'hffffffff);
    rd_check(clk_ctrl_pkg::OFS_PLL_CFG, 32'h00000001, 32'hffffffff);
    complete_run;
  end
endmodule

// ==== rtl/clk_ctrl_pkg.sv ====
// constants, field layouts and types for the system clock source control
// assumes a 32-bit AHB-Lite register port and one 20 MHz bus clock
package clk_ctrl_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_SYS_CFG = 8'h00;
  localparam logic [7:0] OFS_PLL_CFG = 8'h04;
  localparam logic [7:0] OFS_PRESCALE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  // ==========================================================
  // field widths and positions
  localparam int PRE_W = 10;
  localparam int PLL_INPUT_DIV_FIELD_W = 4;
  localparam int PLL_FEEDBACK_MULT_FIELD_W = 7;
  localparam int K2_W = 7;
  localparam int WAIT_W = 3;
  localparam int PER_W = 16;
  localparam int SYS_SRC_LSB = 0;
  localparam int SYS_WAIT_LSB = 4;
  localparam int PLL_BYP_BIT = 0;
  localparam int PLL_REF_BIT = 1;
  localparam int PLL_BAND_LSB = 2;
  localparam int PLL_PLL_INPUT_DIV_FIELD_LSB = 4;
  localparam int PLL_PLL_FEEDBACK_MULT_FIELD_LSB = 8;
  localparam int PLL_K2_LSB = 16;
  localparam int ST_CLK_BIT = 0;
  localparam int ST_PEND_BIT = 1;
  localparam int ST_LOCK_BIT = 2;
  localparam int ST_PLLEN_BIT = 3;
  localparam int ST_SRC_LSB = 4;

  // ==========================================================
  // encodings
  localparam logic [1:0] SEL_WAKEUP = 2'h0;
  localparam logic [1:0] SEL_RESV = 2'h1;
  localparam logic [1:0] SEL_OSC = 2'h2;
  localparam logic [1:0] SEL_DIRECT = 2'h3;
  localparam logic [1:0] BAND_LOW = 2'h0;
  localparam logic [1:0] BAND_HIGH = 2'h1;
  localparam logic [WAIT_W-1:0] WAIT_RST = 3'h4;
  localparam logic [WAIT_W-1:0] WAIT_FORBIDDEN = 3'h0;
  localparam int LOCK_SHIFT = 3;
  localparam logic [PER_W-1:0] EST_RST = 16'hffff;

  // clock configuration carried as one unit
  typedef struct packed {
    logic [1:0] src;
    logic bypass;
    logic ref_int;
    logic [1:0] band;
    logic [PLL_INPUT_DIV_FIELD_W-1:0] pll_input_div_field;
    logic [PLL_FEEDBACK_MULT_FIELD_W-1:0] pll_feedback_mult_field;
    logic [K2_W-1:0] pll_output_div_field;
    logic [PRE_W-1:0] prescale_div_field;
  } clk_cfg_t;

  localparam clk_cfg_t CFG_RST = '{src: SEL_WAKEUP, bypass: 1'b1, ref_int: 1'b0,
    band: BAND_LOW, pll_input_div_field: 4'h0, pll_feedback_mult_field: 7'h0, pll_output_div_field: 7'h0, prescale_div_field: 10'h000};

  // glitch-free switch sequencer
  typedef enum logic [2:0] {
    SW_RUN = 3'b001,
    SW_WAIT_LOW = 3'b010,
    SW_LOAD = 3'b100
  } sw_state_t;
endpackage

// ==== rtl/flash_wait_ctrl.sv ====
// flash access waitstate sequencer
// assumes sys_tick is a one-cycle pulse per system clock period
`timescale 1ns/1ps
module flash_wait_ctrl #(
  parameter int WAIT_W = 3
) (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, active low
  input wire logic sys_tick, // one pulse per system clock
  input wire logic [WAIT_W-1:0] wait_count, // configured waitstates
  input wire logic acc_req, // flash access pending, held until ready
  input wire logic acc_seq, // access is sequential
  output logic acc_ready // access completes this cycle
);
  logic busy_r;
  logic [WAIT_W-1:0] cnt_r;
  logic done;

  // ==========================================================
  // waitstate counting
  assign done = busy_r && (cnt_r == wait_count);
  // sequential accesses come from prefetch and pay nothing
  assign acc_ready = acc_req && (acc_seq || done);

  // busy flag for a non-sequential access
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_r <= 1'b0;
    end else if (acc_ready) begin
      busy_r <= 1'b0;
    end else if (acc_req && !acc_seq) begin
      busy_r <= 1'b1;
    end
  end

  // one waitstate per system clock tick, field taken as the count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
    end else if (!busy_r) begin
      cnt_r <= '0;
    end else if (sys_tick && !done) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // ==========================================================
  // checks
  seq_no_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
    acc_req && acc_seq |-> acc_ready)
    else $error("sequential flash access was delayed");
  nonseq_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
    acc_ready && !acc_seq |-> busy_r && cnt_r == wait_count)
    else $error("non-sequential access ended before its waitstates");
endmodule

// ==== rtl/sys_clk_ctrl.sv ====
// system clock source selection, prescaler, pll model and flash waitstates
// assumes AHB-Lite single-word transfers; source inputs are async pins far
// below hclk/2, and the pll vco edge rate stays below the bus clock rate
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - waitstates only on non-sequential flash accesses
// - waitstate field value is the waitstate count
// - select 11 passes external clock pin directly
// - crystal bypass, factor one equals direct drive
// - select 10 bypass divides oscillator by K1
// - prescaler input is crystal or internal source
// - prescale factor one passes oscillator levels unchanged
// - prescale factor reaches 1024 at most
// - select 10 no bypass enables pll output
// - pll factor is N over P times K2
// - pll reference is crystal or internal source
// - pll tracks its reference gradually, no jumps
// - system clock is vco divided by K2
// - vco band 00 low, 01 high, 1X reserved
// - select 00 takes the wakeup clock
module sys_clk_ctrl (
  input wire logic hclk, // bus clock, 20 MHz
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic ext_clock_pin, // direct drive clock pin
  input wire logic crystal_input_pin, // oscillator clock pin
  input wire logic int_clk_src, // internal clock source
  input wire logic wakeup_clk_src, // low-frequency wakeup source
  output logic sys_clk, // generated system clock level
  output logic sys_clk_rise, // pulse on each system clock rise
  output logic pll_enable, // pll running
  input wire logic flash_req, // flash access pending
  input wire logic flash_seq, // flash access sequential
  output logic flash_ready // flash access completes
);
  clk_ctrl_pkg::clk_cfg_t cfg_r, act_r;
  clk_ctrl_pkg::sw_state_t sw_state_r;
  logic [clk_ctrl_pkg::WAIT_W-1:0] wait_r;
  logic [3:0] sync1_r, sync2_r, sync3_r;
  logic ext_lvl, osc_lvl, wu_lvl, osc_rise;
  logic [clk_ctrl_pkg::PRE_W-1:0] pre_cnt_r;
  logic pre_lvl;
  logic [clk_ctrl_pkg::PRE_W-1:0] pre_half;
  logic [clk_ctrl_pkg::PLL_INPUT_DIV_FIELD_W-1:0] p_cnt_r;
  logic ref_tick;
  logic [clk_ctrl_pkg::PER_W-1:0] per_cnt_r, meas_r, est_r, est_step;
  logic [clk_ctrl_pkg::PER_W:0] acc_r, acc_sum;
  logic vco_edge;
  logic [clk_ctrl_pkg::K2_W-1:0] k2_cnt_r;
  logic pll_lvl_r, pll_on;
  logic mux_lvl, load, sys_clk_r, rise_r;
  logic aph_wr_r, aph_rd_r, rd_wait_r;
  logic [7:0] addr_r;
  logic [31:0] hrdata_r, rd_val, status;
  logic accept;

  // ==========================================================
  // pin synchronisers: ext, crystal, internal, wakeup
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      sync3_r <= 4'h0;
    end else begin
      sync1_r <= {wakeup_clk_src, int_clk_src, crystal_input_pin, ext_clock_pin};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end
  assign ext_lvl = sync2_r[0];
  assign wu_lvl = sync2_r[3];
  // oscillator is the crystal pin or the internal source
  assign osc_lvl = act_r.ref_int ? sync2_r[2] : sync2_r[1];
  assign osc_rise = osc_lvl && !(act_r.ref_int ? sync3_r[2] : sync3_r[1]);
  // ==========================================================
  // prescaler: K1 = field + 1, up to 1024
  assign pre_half = clk_ctrl_pkg::PRE_W'((11'(act_r.prescale_div_field) + 11'h2) >> 1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_r <= '0;
    end else if (load) begin
      pre_cnt_r <= '0;
    end else if (osc_rise) begin
      pre_cnt_r <= (pre_cnt_r >= act_r.prescale_div_field) ? '0 : pre_cnt_r + 1'b1;
    end
  end
  // factor one follows the oscillator level itself, keeping its duty
  assign pre_lvl = (act_r.prescale_div_field == '0) ? osc_lvl : (pre_cnt_r < pre_half);
  // ==========================================================
  // pll model: reference divided by P, vco locked to 2N edges per period
  assign pll_on = (act_r.src == clk_ctrl_pkg::SEL_OSC) && !act_r.bypass;
  assign ref_tick = pll_on && osc_rise && (p_cnt_r == act_r.pll_input_div_field);
  // reference divider P
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p_cnt_r <= '0;
    end else if (!pll_on || ref_tick) begin
      p_cnt_r <= '0;
    end else if (osc_rise) begin
      p_cnt_r <= p_cnt_r + 1'b1;
    end
  end
  // reference period measurement in bus cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_cnt_r <= '0;
      meas_r <= clk_ctrl_pkg::EST_RST;
    end else if (ref_tick) begin
      per_cnt_r <= 16'h0001;
      meas_r <= per_cnt_r;
    end else if (pll_on && per_cnt_r != clk_ctrl_pkg::EST_RST) begin
      per_cnt_r <= per_cnt_r + 1'b1;
    end
  end
  // estimate walks toward the measurement by an eighth of the gap
  always_comb begin
    est_step = ((est_r > meas_r) ? est_r - meas_r : meas_r - est_r) >> clk_ctrl_pkg::LOCK_SHIFT;
    if (est_step == '0) begin
      est_step = 16'h0001;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      est_r <= clk_ctrl_pkg::EST_RST;
    end else if (ref_tick && est_r > meas_r) begin
      est_r <= est_r - est_step;
    end else if (ref_tick && est_r < meas_r && meas_r > 16'h0001) begin
      est_r <= est_r + est_step;
    end
  end
  // vco edges: 2N per estimated reference period
  assign acc_sum = acc_r + {9'h000, act_r.pll_feedback_mult_field + 1'b1, 1'b0};
  assign vco_edge = pll_on && (acc_sum >= {1'b0, est_r});
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r <= '0;
    end else if (!pll_on) begin
      acc_r <= '0;
    end else begin
      acc_r <= vco_edge ? acc_sum - {1'b0, est_r} : acc_sum;
    end
  end
  // output divider K2 on vco edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      k2_cnt_r <= '0;
      pll_lvl_r <= 1'b0;
    end else if (load || !pll_on) begin
      k2_cnt_r <= '0;
      pll_lvl_r <= 1'b0;
    end else if (vco_edge) begin
      k2_cnt_r <= (k2_cnt_r == act_r.pll_output_div_field) ? '0 : k2_cnt_r + 1'b1;
      pll_lvl_r <= (k2_cnt_r == act_r.pll_output_div_field) ? !pll_lvl_r : pll_lvl_r;
    end
  end

  // ==========================================================
  // source multiplexer
  always_comb begin
    case (act_r.src)
      clk_ctrl_pkg::SEL_DIRECT: mux_lvl = ext_lvl;
      clk_ctrl_pkg::SEL_OSC: mux_lvl = act_r.bypass ? pre_lvl : pll_lvl_r;
      clk_ctrl_pkg::SEL_WAKEUP: mux_lvl = wu_lvl;
      default: mux_lvl = 1'b0;
    endcase
  end
  // switch sequencer: change only while low, then wait for a low start
  assign load = (sw_state_r == clk_ctrl_pkg::SW_WAIT_LOW) && !mux_lvl && !sys_clk_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_state_r <= clk_ctrl_pkg::SW_RUN;
      act_r <= clk_ctrl_pkg::CFG_RST;
    end else begin
      case (sw_state_r)
        clk_ctrl_pkg::SW_RUN: begin
          if (cfg_r != act_r) begin
            sw_state_r <= clk_ctrl_pkg::SW_WAIT_LOW;
          end
        end
        clk_ctrl_pkg::SW_WAIT_LOW: begin
          if (load) begin
            act_r <= cfg_r;
            sw_state_r <= clk_ctrl_pkg::SW_LOAD;
          end
        end
        clk_ctrl_pkg::SW_LOAD: begin
          if (!mux_lvl) begin
            sw_state_r <= clk_ctrl_pkg::SW_RUN;
          end
        end
        default: sw_state_r <= clk_ctrl_pkg::SW_RUN;
      endcase
    end
  end
  // registered clock level, held low while a new source settles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_clk_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      sys_clk_r <= (sw_state_r == clk_ctrl_pkg::SW_LOAD) ? 1'b0 : mux_lvl;
      rise_r <= (sw_state_r != clk_ctrl_pkg::SW_LOAD) && mux_lvl && !sys_clk_r;
    end
  end
  assign sys_clk = sys_clk_r;
  assign sys_clk_rise = rise_r;
  assign pll_enable = pll_on;
  // ==========================================================
  // flash waitstates
  flash_wait_ctrl #(.WAIT_W(clk_ctrl_pkg::WAIT_W)) u_flash_wait (
    .hclk(hclk),
    .hresetn(hresetn),
    .sys_tick(rise_r),
    .wait_count(wait_r),
    .acc_req(flash_req),
    .acc_seq(flash_seq),
    .acc_ready(flash_ready)
  );

  // ==========================================================
  // AHB-Lite slave: writes zero wait, reads one wait state
  assign accept = hsel && htrans[1] && hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_wr_r <= 1'b0;
      aph_rd_r <= 1'b0;
      rd_wait_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      if (hready) begin
        aph_wr_r <= accept && hwrite;
        aph_rd_r <= accept && !hwrite;
        addr_r <= accept ? haddr[7:0] : addr_r;
      end
      rd_wait_r <= accept && !hwrite;
    end
  end
  // configuration writes; reserved and forbidden codes are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r <= clk_ctrl_pkg::CFG_RST;
      wait_r <= clk_ctrl_pkg::WAIT_RST;
    end else if (aph_wr_r && addr_r == clk_ctrl_pkg::OFS_SYS_CFG) begin
      if (hwdata[clk_ctrl_pkg::SYS_SRC_LSB +: 2] != clk_ctrl_pkg::SEL_RESV) begin
        cfg_r.src <= hwdata[clk_ctrl_pkg::SYS_SRC_LSB +: 2];
      end
      if (hwdata[clk_ctrl_pkg::SYS_WAIT_LSB +: 3] != clk_ctrl_pkg::WAIT_FORBIDDEN) begin
        wait_r <= hwdata[clk_ctrl_pkg::SYS_WAIT_LSB +: 3];
      end
    end else if (aph_wr_r && addr_r == clk_ctrl_pkg::OFS_PLL_CFG) begin
      cfg_r.bypass <= hwdata[clk_ctrl_pkg::PLL_BYP_BIT];
      cfg_r.ref_int <= hwdata[clk_ctrl_pkg::PLL_REF_BIT];
      if (!hwdata[clk_ctrl_pkg::PLL_BAND_LSB + 1]) begin
        cfg_r.band <= hwdata[clk_ctrl_pkg::PLL_BAND_LSB +: 2];
      end
      cfg_r.pll_input_div_field <= hwdata[clk_ctrl_pkg::PLL_PLL_INPUT_DIV_FIELD_LSB +: clk_ctrl_pkg::PLL_INPUT_DIV_FIELD_W];
      cfg_r.pll_feedback_mult_field <= hwdata[clk_ctrl_pkg::PLL_PLL_FEEDBACK_MULT_FIELD_LSB +: clk_ctrl_pkg::PLL_FEEDBACK_MULT_FIELD_W];
      cfg_r.pll_output_div_field <= hwdata[clk_ctrl_pkg::PLL_K2_LSB +: clk_ctrl_pkg::K2_W];
    end else if (aph_wr_r && addr_r == clk_ctrl_pkg::OFS_PRESCALE) begin
      cfg_r.prescale_div_field <= hwdata[clk_ctrl_pkg::PRE_W-1:0];
    end
  end
  // read multiplexer, unmapped offsets read zero; no lock before a real measurement
  assign status = {24'h000000, 2'b00, act_r.src, pll_on,
    (est_r == meas_r) && (meas_r != clk_ctrl_pkg::EST_RST) && pll_on,
    sw_state_r != clk_ctrl_pkg::SW_RUN, sys_clk_r};
  always_comb begin
    case (addr_r)
      clk_ctrl_pkg::OFS_SYS_CFG: rd_val = {25'h0000000, wait_r, 2'b00, cfg_r.src};
      clk_ctrl_pkg::OFS_PLL_CFG: rd_val = {9'h000, cfg_r.pll_output_div_field, 1'b0, cfg_r.pll_feedback_mult_field,
        cfg_r.pll_input_div_field, cfg_r.band, cfg_r.ref_int, cfg_r.bypass};
      clk_ctrl_pkg::OFS_PRESCALE: rd_val = {22'h000000, cfg_r.prescale_div_field};
      clk_ctrl_pkg::OFS_STATUS: rd_val = status;
      default: rd_val = 32'h00000000;
    endcase
  end
  // read data captured in the wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
    end else if (rd_wait_r && aph_rd_r) begin
      hrdata_r <= rd_val;
    end
  end
  assign hrdata = hrdata_r;
  assign hreadyout = !rd_wait_r;
  assign hresp = 1'b0;

  // ==========================================================
  // checks
  direct_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sw_state_r == clk_ctrl_pkg::SW_RUN && act_r.src == clk_ctrl_pkg::SEL_DIRECT
    |=> sys_clk_r == $past(sync2_r[0]) || sw_state_r != clk_ctrl_pkg::SW_RUN)
    else $error("direct drive clock does not follow the pin");
  wakeup_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sw_state_r == clk_ctrl_pkg::SW_RUN && act_r.src == clk_ctrl_pkg::SEL_WAKEUP
    |=> sys_clk_r == $past(sync2_r[3]) || sw_state_r != clk_ctrl_pkg::SW_RUN)
    else $error("wakeup clock not passed through");
  unity_prescale_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sw_state_r == clk_ctrl_pkg::SW_RUN && act_r.src == clk_ctrl_pkg::SEL_OSC
    && act_r.bypass && act_r.prescale_div_field == '0 && !act_r.ref_int
    |=> sys_clk_r == $past(sync2_r[1]) || sw_state_r != clk_ctrl_pkg::SW_RUN)
    else $error("prescale factor one altered the oscillator");
  prescale_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
    osc_rise && pre_cnt_r == act_r.prescale_div_field && !load |=> pre_cnt_r == '0)
    else $error("prescaler count passed its factor");
  pll_drives_clk_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sw_state_r == clk_ctrl_pkg::SW_RUN && pll_on |=> sys_clk_r == $past(pll_lvl_r))
    else $error("pll output not driving the system clock");
  k2_divide_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pll_on && !load && $changed(pll_lvl_r) && $past(pll_on)
    |-> $past(vco_edge) && $past(k2_cnt_r) == $past(act_r.pll_output_div_field))
    else $error("pll output toggled off its K2 boundary");
  smooth_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(est_r) |-> ((est_r > $past(est_r)) ? est_r - $past(est_r)
    : $past(est_r) - est_r) <= ($past(est_r) >> 3) + 16'h0001)
    else $error("pll estimate jumped");
  glitch_free_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(act_r) |-> !$past(sys_clk_r) && !sys_clk_r ##1 !sys_clk_r)
    else $error("clock switched while high");
  band_valid_a: assert property (@(posedge hclk) disable iff (!hresetn)
    aph_wr_r && addr_r == clk_ctrl_pkg::OFS_PLL_CFG && hwdata[3] |=> $stable(cfg_r.band))
    else $error("reserved vco band accepted");
endmodule
